// *** hw/zdc_top.v ***
// Zoom oscillator, decimation control and count latch readback
`timescale 1ns/10ps
`default_nettype none
`include "zdc_defines.vh"

module zdc_top #(
  parameter DW         = 16,
  parameter FIFO_DEPTH = 8,
  parameter [39:0] PHASE_INIT = 40'h00_0000_0000
) (
  // Clock and reset
  input  wire            i_clk_sys,
  input  wire            i_arst_n,
  // Register bus, 16-bit
  input  wire [6:0]      i_bus_addr,
  input  wire            i_bus_wr,
  input  wire            i_bus_rd,
  input  wire [15:0]     i_bus_wdata,
  output reg  [15:0]     o_bus_rdata,
  output reg             o_bus_ack,
  // Timing line and measurement loop status
  input  wire            i_sync,
  input  wire            i_trig_state,
  input  wire [1:0]      i_meas_code,
  input  wire            i_armed,
  input  wire            i_trig,
  input  wire [1:0]      i_pack_shift,
  // Converter calibration controls
  output reg  [2:0]      o_converter_cal_mode,
  output reg             o_cal_reset,
  output reg             o_cal_dither,
  output reg             o_cal_gain_corr,
  output reg             o_cal_dac_corr,
  output reg             o_cal_err_update,
  // Sample input stream
  input  wire            i_smp_valid,
  output wire            o_smp_ready,
  input  wire [DW-1:0]   i_smp_data,
  // Complex output stream
  output wire            o_out_valid,
  input  wire            i_out_ready,
  output wire [DW-1:0]   o_out_i,
  output wire [DW-1:0]   o_out_q
);
  localparam AW = `ZDC_ACC_W;
  localparam SW = DW + 25;

  //--------------------------------------------------------------
  // Reset release and timing line synchroniser
  //--------------------------------------------------------------
  reg rst_s1_r;
  reg rst_n;
  reg sync_s1_r;
  reg sync_s2_r;
  reg sync_d_r;
  wire sync_fall = sync_d_r & ~sync_s2_r;

  // Reset is released through two flops
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // The second and third stages feed the edge detector
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_s1_r <= 1'b1;
      sync_s2_r <= 1'b1;
      sync_d_r  <= 1'b1;
    end else begin
      sync_s1_r <= i_sync;
      sync_s2_r <= sync_s1_r;
      sync_d_r  <= sync_s2_r;
    end
  end

  //--------------------------------------------------------------
  // Register state
  //--------------------------------------------------------------
  reg [4:0]  sel_r;
  reg [7:0]  ctl_r;
  reg [10:0] coarse_r;
  reg [28:0] fine_r;
  reg [AW-1:0] freq_r;
  reg [AW-1:0] phase_r;
  reg [24:0] dcnt_r;
  reg [24:0] latch_r;
  reg [1:0]  shift_r;
  reg        alt_r;
  reg        xfer_pend_r;
  reg        clr_dec;

  wire wr_any = i_bus_wr;
  wire wr_ctl = wr_any & (i_bus_addr == `ZDC_A_MIX_CTL);
  wire wr_cap = wr_any & (i_bus_addr == `ZDC_A_LATCH_HI);
  wire wr_clr = wr_any & (i_bus_addr == `ZDC_A_LATCH_MID);
  wire wr_xf  = wr_any & (i_bus_addr == `ZDC_A_XFER);
  wire trig_ev = i_trig & i_armed;

  // Transfer events: delayed strobe, armed trigger, trigger-state high fall, code 01 fall
  wire xfer_go = xfer_pend_r | trig_ev
               | (sync_fall & i_trig_state)
               | (sync_fall & (i_meas_code == 2'b01));
  wire do_init = sync_fall & ctl_r[`ZDC_CTL_RST_BIT];

  // Opcode decode: store moves staging to accumulators
  wire [3:0] op   = ctl_r[3:0];
  wire is_store   = (op == 4'h1) | op[3];
  wire is_recall  = ~op[3] & (op[2:1] != 2'b00);
  wire use_c = (op == 4'h1) | (op == 4'h8) | (op == 4'hA) | (op == 4'hB)
             | (op == 4'hE) | (op == 4'hF) | (op == 4'h2) | (op == 4'h3)
             | (op == 4'h6) | (op == 4'h7);
  wire use_f = (op == 4'h1) | (op == 4'h9) | (op == 4'hC) | (op == 4'hD)
             | (op == 4'hE) | (op == 4'hF) | (op == 4'h4) | (op == 4'h5)
             | (op == 4'h6) | (op == 4'h7);
  wire to_f  = (op == 4'h1) | (op == 4'h8) | (op == 4'h9) | (op == 4'hA)
             | (op == 4'hC) | (op == 4'hE)
             | (is_recall & ~op[0]);
  wire to_p  = (op == 4'h1) | (op == 4'h8) | (op == 4'h9) | (op == 4'hB)
             | (op == 4'hD) | (op == 4'hF)
             | (is_recall & op[0]);
  wire [AW-1:0] src_w = to_f ? freq_r : phase_r;

  //--------------------------------------------------------------
  // Bus writes of control and staging
  //--------------------------------------------------------------
  // Write wins over the clear bit's own self-clear in one cycle
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_r   <= `ZDC_RST_SEL;
      ctl_r   <= `ZDC_RST_CTL;
      o_converter_cal_mode <= `ZDC_RST_CAL;
      coarse_r <= 11'h000;
      fine_r   <= 29'h0000_0000;
      xfer_pend_r <= 1'b0;
    end else begin
      xfer_pend_r <= wr_xf;
      if (wr_any & (i_bus_addr == `ZDC_A_LATCH_LO))
        sel_r <= i_bus_wdata[4:0];
      if (wr_any & (i_bus_addr == `ZDC_A_CAL_CTL))
        o_converter_cal_mode <= i_bus_wdata[7:5];
      // Recall pulls accumulators into staging
      if (xfer_go & is_recall & use_c)
        coarse_r <= src_w[39:29];
      else if (wr_any & (i_bus_addr == `ZDC_A_COARSE_HI))
        coarse_r[10:3] <= i_bus_wdata[7:0];
      else if (wr_any & (i_bus_addr == `ZDC_A_COARSE_LO))
        coarse_r[2:0] <= i_bus_wdata[7:5];
      if (xfer_go & is_recall & use_f)
        fine_r <= src_w[28:0];
      else if (wr_any & (i_bus_addr == `ZDC_A_FINE_B3))
        fine_r[28:21] <= i_bus_wdata[7:0];
      else if (wr_any & (i_bus_addr == `ZDC_A_FINE_B2))
        fine_r[20:13] <= i_bus_wdata[7:0];
      else if (wr_any & (i_bus_addr == `ZDC_A_FINE_B1))
        fine_r[12:5] <= i_bus_wdata[7:0];
      else if (wr_any & (i_bus_addr == `ZDC_A_FINE_B0))
        fine_r[4:0] <= i_bus_wdata[7:3];
      // Control register: init, host write, then self-clear
      if (do_init)
        ctl_r <= 8'h00;
      else if (wr_ctl)
        ctl_r <= {i_bus_wdata[7:6], 1'b0, i_bus_wdata[4:0]};
      else if (xfer_go)
        ctl_r[`ZDC_CTL_CLR_BIT] <= 1'b0;
    end
  end

  // Calibration mode decode into converter controls
  always @* begin
    o_cal_reset      = (o_converter_cal_mode == `ZDC_CAL_RESET);
    o_cal_dither     = (o_converter_cal_mode >= 3'h2);
    o_cal_gain_corr  = (o_converter_cal_mode == 3'h3) | (o_converter_cal_mode >= 3'h5);
    o_cal_dac_corr   = (o_converter_cal_mode >= 3'h4);
    o_cal_err_update = (o_converter_cal_mode == 3'h3) | (o_converter_cal_mode == 3'h4)
                     | (o_converter_cal_mode == `ZDC_CAL_FULL);
  end

  //--------------------------------------------------------------
  // Oscillator accumulators
  //--------------------------------------------------------------
  wire fifo_rdy;
  wire take = i_smp_valid & fifo_rdy;
  wire [AW-1:0] stg_w = {use_c ? coarse_r : 11'h000, use_f ? fine_r : 29'h0000_0000};
  assign o_smp_ready = fifo_rdy;

  // Store updates chosen halves, else phase steps by frequency
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      freq_r  <= {AW{1'b0}};
      phase_r <= {AW{1'b0}};
    end else if (do_init) begin
      freq_r  <= {AW{1'b0}};
      phase_r <= PHASE_INIT;
    end else begin
      if (xfer_go & is_store & to_f)
        freq_r <= {use_c ? coarse_r : freq_r[39:29],
                   use_f ? fine_r : freq_r[28:0]};
      if (xfer_go & is_store & to_p)
        phase_r <= {stg_w[39:29] | (use_c ? 11'h000 : phase_r[39:29]),
                    use_f ? fine_r : phase_r[28:0]};
      else if (take)
        phase_r <= phase_r + freq_r;
    end
  end

  // Quarter-resolution sine table, 16 points per cycle
  function signed [7:0] sin_lut;
    input [3:0] idx;
    begin
      case (idx)
        4'h0, 4'h8: sin_lut = 8'sd0;
        4'h1, 4'h7: sin_lut = 8'sd49;
        4'h2, 4'h6: sin_lut = 8'sd90;
        4'h3, 4'h5: sin_lut = 8'sd118;
        4'h4:       sin_lut = 8'sd127;
        4'h9, 4'hF: sin_lut = -8'sd49;
        4'hA, 4'hE: sin_lut = -8'sd90;
        4'hB, 4'hD: sin_lut = -8'sd118;
        default:    sin_lut = -8'sd127;
      endcase
    end
  endfunction

  wire [AW-1:0] ph_nxt = phase_r + freq_r;
  wire signed [7:0] cos_w = sin_lut(ph_nxt[39:36] + 4'h4);
  wire signed [7:0] sin_w = sin_lut(ph_nxt[39:36]);
  wire signed [DW+7:0] mi_w = $signed(i_smp_data) * cos_w;
  wire signed [DW+7:0] mq_w = $signed(i_smp_data) * sin_w;
  wire signed [DW-1:0] mi_t = mi_w[DW+6:7];
  wire signed [DW-1:0] mq_t = mq_w[DW+6:7];

  //--------------------------------------------------------------
  // Mixer lowpass (two-tap average)
  //--------------------------------------------------------------
  reg signed [DW-1:0] lp_i_r;
  reg signed [DW-1:0] lp_q_r;
  wire signed [DW:0] si_w = $signed({mi_t[DW-1], mi_t}) + $signed({lp_i_r[DW-1], lp_i_r});
  wire signed [DW:0] sq_w = $signed({mq_t[DW-1], mq_t}) + $signed({lp_q_r[DW-1], lp_q_r});
  wire filt = ctl_r[`ZDC_CTL_FILT_BIT];
  wire signed [DW-1:0] fi_w = filt ? si_w[DW:1] : mi_t;
  wire signed [DW-1:0] fq_w = filt ? sq_w[DW:1] : mq_t;

  // Clear occurs at the transfer event when armed by the clear bit
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lp_i_r <= {DW{1'b0}};
      lp_q_r <= {DW{1'b0}};
    end else if (do_init | (xfer_go & ctl_r[`ZDC_CTL_CLR_BIT])) begin
      lp_i_r <= {DW{1'b0}};
      lp_q_r <= {DW{1'b0}};
    end else if (take) begin
      lp_i_r <= mi_t;
      lp_q_r <= mq_t;
    end
  end

  //--------------------------------------------------------------
  // Decimation: averaging over 2^N samples
  //--------------------------------------------------------------
  reg signed [SW-1:0] acc_i_r;
  reg signed [SW-1:0] acc_q_r;
  wire [24:0] mask_w = (25'h000_0001 << sel_r) - 25'h000_0001;
  wire dec_end = ((dcnt_r & mask_w) == mask_w);
  wire signed [SW-1:0] ni_w = acc_i_r + {{(SW-DW){fi_w[DW-1]}}, fi_w};
  wire signed [SW-1:0] nq_w = acc_q_r + {{(SW-DW){fq_w[DW-1]}}, fq_w};
  wire signed [SW-1:0] oi_w = ni_w >>> sel_r;
  wire signed [SW-1:0] oq_w = nq_w >>> sel_r;
  wire bypass = (sel_r == 5'h00);
  wire emit = take & (bypass | dec_end);
  wire [2*DW-1:0] fifo_in = bypass ? {fi_w, fq_w} : {oi_w[DW-1:0], oq_w[DW-1:0]};

  always @* begin
    clr_dec = wr_clr;
  end

  // Counter runs on every sample; clear touches only accumulators
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dcnt_r  <= 25'h000_0000;
      acc_i_r <= {SW{1'b0}};
      acc_q_r <= {SW{1'b0}};
    end else begin
      if (take)
        dcnt_r <= dcnt_r + 25'h000_0001;
      if (clr_dec | (take & (bypass | dec_end))) begin
        acc_i_r <= {SW{1'b0}};
        acc_q_r <= {SW{1'b0}};
      end else if (take) begin
        acc_i_r <= ni_w;
        acc_q_r <= nq_w;
      end
    end
  end

  // Latch captured on host strobe or on the trigger, then held
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= 25'h000_0000;
      shift_r <= 2'b00;
      alt_r   <= 1'b0;
    end else if (wr_cap | trig_ev) begin
      latch_r <= dcnt_r;
      shift_r <= i_pack_shift;
      alt_r   <= dcnt_r[0];
    end
  end

  //--------------------------------------------------------------
  // Output FIFO
  //--------------------------------------------------------------
  zdc_fifo #(
    .W     (2*DW),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (rst_n),
    .i_in_valid  (emit),
    .o_in_ready  (fifo_rdy),
    .i_in_data   (fifo_in),
    .o_out_valid (o_out_valid),
    .i_out_ready (i_out_ready),
    .o_out_data  ({o_out_i, o_out_q})
  );

  //--------------------------------------------------------------
  // Bus reads, one cycle later with ack
  //--------------------------------------------------------------
  reg [15:0] rd_nxt;
  always @* begin
    case (i_bus_addr)
      `ZDC_A_LATCH_LO:  rd_nxt = {5'h00, alt_r, shift_r, latch_r[7:0]};
      `ZDC_A_LATCH_MID: rd_nxt = {8'h00, latch_r[15:8]};
      `ZDC_A_LATCH_HI:  rd_nxt = {8'h00, latch_r[23:16]};
      `ZDC_A_LATCH_TOP: rd_nxt = {15'h0000, latch_r[24]};
      `ZDC_A_COARSE_HI: rd_nxt = {8'h00, coarse_r[10:3]};
      `ZDC_A_COARSE_LO: rd_nxt = {8'h00, coarse_r[2:0], 5'h00};
      `ZDC_A_FINE_B3:   rd_nxt = {8'h00, fine_r[28:21]};
      `ZDC_A_FINE_B2:   rd_nxt = {8'h00, fine_r[20:13]};
      `ZDC_A_FINE_B1:   rd_nxt = {8'h00, fine_r[12:5]};
      `ZDC_A_FINE_B0:   rd_nxt = {8'h00, fine_r[4:0], 3'b000};
      default:          rd_nxt = 16'h0000;
    endcase
  end

  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_bus_rdata <= 16'h0000;
      o_bus_ack   <= 1'b0;
    end else begin
      o_bus_ack <= i_bus_rd | i_bus_wr;
      if (i_bus_rd)
        o_bus_rdata <= rd_nxt;
    end
  end
endmodule // zdc_top
`default_nettype wire

// *** hw/zdc_defines.vh ***
// Register offsets, field positions and reset values of the zoom/decimation control
`ifndef ZDC_DEFINES_VH
`define ZDC_DEFINES_VH
// Byte addresses of the 16-bit register bus
`define ZDC_A_CAL_CTL     7'h26
`define ZDC_A_LATCH_LO    7'h28
`define ZDC_A_LATCH_MID   7'h2A
`define ZDC_A_LATCH_HI    7'h2C
`define ZDC_A_LATCH_TOP   7'h2E
`define ZDC_A_COARSE_HI   7'h30
`define ZDC_A_COARSE_LO   7'h32
`define ZDC_A_FINE_B3     7'h34
`define ZDC_A_FINE_B2     7'h36
`define ZDC_A_FINE_B1     7'h38
`define ZDC_A_FINE_B0     7'h3A
`define ZDC_A_MIX_CTL     7'h3C
`define ZDC_A_XFER        7'h3E
// Field positions
`define ZDC_CAL_MODE_LSB  5
`define ZDC_CTL_FILT_BIT  4
`define ZDC_CTL_CLR_BIT   6
`define ZDC_CTL_RST_BIT   7
`define ZDC_SEL_MAX       5'h18
// Widths of staging halves and accumulators
`define ZDC_COARSE_W      11
`define ZDC_FINE_W        29
`define ZDC_ACC_W         40
// Reset values
`define ZDC_RST_CTL       8'h00
`define ZDC_RST_CAL       3'h0
`define ZDC_RST_SEL       5'h00
// Converter calibration mode codes
`define ZDC_CAL_RESET     3'h0
`define ZDC_CAL_FULL      3'h7
`endif

// *** hw/zdc_fifo.v ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module zdc_fifo #(
  parameter W     = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire          i_clk_sys,
  input  wire          i_rst_n,
  // Fill side
  input  wire          i_in_valid,
  output wire          o_in_ready,
  input  wire [W-1:0]  i_in_data,
  // Drain side
  output wire          o_out_valid,
  input  wire          i_out_ready,
  output reg  [W-1:0]  o_out_data
);
  reg [W-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  wire push;
  wire pop;

  // Honest flags from the occupancy count
  assign o_in_ready  = (cnt_r != DEPTH[AW:0]);
  assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
  assign push = i_in_valid & o_in_ready;
  assign pop  = o_out_valid & i_out_ready;

  // Storage write, no reset needed for data
  always @(posedge i_clk_sys) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  // Head word read combinationally from storage at the read pointer
  always @* begin
    o_out_data = mem_r[rp_r];
  end

  // Pointers and count
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // zdc_fifo
`default_nettype wire

// *** dv/zdc_bus_ctl.sv ***
// Bus controller model issuing 16-bit register accesses
`timescale 1ns/10ps
`default_nettype none
module zdc_bus_ctl (
  // Clock
  input  wire logic        i_clk_sys,
  // Register bus toward the device
  output var  logic [6:0]  o_addr,
  output var  logic        o_wr,
  output var  logic        o_rd,
  output var  logic [15:0] o_wdata,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_ack
);
  // Idle bus at time zero
  initial begin
    o_addr  = 7'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 16'h0000;
  end
  // Decimation select is capped at the valid maximum of 24
  function automatic logic [15:0] sel_word(input int n);
    return (n > 24) ? 16'h0018 : 16'(n);
  endfunction
  // One-cycle strobe; ack and read data are taken one cycle later
  task automatic access(input logic w, input logic [6:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    @(negedge i_clk_sys);
    o_addr  = a;
    o_wdata = d;
    o_wr    = w;
    o_rd    = ~w;
    @(negedge i_clk_sys);
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    q       = i_rdata;
    ok      = i_ack;
    o_wdata = ~d;  // Released data must not look valid
    o_addr  = ~a;
  endtask
endmodule  // zdc_bus_ctl
`default_nettype wire

// *** dv/zdc_top_sva.sv ***
// Port checker for the zoom/decimation control block
`timescale 1ns/10ps
`default_nettype none
module zdc_top_sva (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_arst_n,
  // Register bus
  input wire logic [6:0]  i_bus_addr,
  input wire logic        i_bus_wr,
  input wire logic        i_bus_rd,
  input wire logic [15:0] i_bus_wdata,
  input wire logic [15:0] o_bus_rdata,
  input wire logic        o_bus_ack,
  // Calibration and stream
  input wire logic [2:0]  o_converter_cal_mode,
  input wire logic        o_cal_reset,
  input wire logic        o_cal_dither,
  input wire logic        o_cal_dac_corr,
  input wire logic        o_out_valid,
  input wire logic        i_out_ready,
  input wire logic [15:0] o_out_i
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // Bus answer timing
  chk_bus_ack: assert property ((i_bus_rd || i_bus_wr) |=> o_bus_ack)
    else $error("access not acknowledged");
  chk_ack_cause: assert property (o_bus_ack |-> $past(i_bus_rd || i_bus_wr))
    else $error("ack without access");
  // Calibration mode register and its decode
  chk_cal_write: assert property (i_bus_wr && i_bus_addr == 7'h26 |=>
    o_converter_cal_mode == $past(i_bus_wdata[7:5])) else $error("cal mode not stored");
  chk_cal_reset: assert property (o_cal_reset == (o_converter_cal_mode == 3'h0))
    else $error("cal reset decode wrong");
  chk_cal_decode: assert property (o_cal_dither == (o_converter_cal_mode >= 3'h2) &&
    o_cal_dac_corr == (o_converter_cal_mode >= 3'h4)) else $error("cal decode wrong");
  // Unused read bits stay zero
  chk_coarse_pad: assert property (i_bus_rd && i_bus_addr == 7'h32 |=>
    o_bus_rdata[4:0] == 5'h00 && o_bus_rdata[15:8] == 8'h00) else $error("coarse pad");
  chk_fine_pad: assert property (i_bus_rd && i_bus_addr == 7'h3A |=>
    o_bus_rdata[2:0] == 3'h0 && o_bus_rdata[15:8] == 8'h00) else $error("fine pad");
  chk_latch_top: assert property (i_bus_rd && i_bus_addr == 7'h2E |=>
    o_bus_rdata[15:1] == 15'h0000) else $error("latch top pad");
  chk_ctl_wonly: assert property (i_bus_rd && i_bus_addr == 7'h3C |=>
    o_bus_rdata == 16'h0000) else $error("write-only read not zero");
  // Output word stands while the far side stalls
  chk_out_hold: assert property (o_out_valid && !i_out_ready |=>
    o_out_valid && $stable(o_out_i)) else $error("output dropped during stall");
  cov_latch_rd: cover property (i_bus_rd && i_bus_addr == 7'h28);
  cov_xfer: cover property (i_bus_wr && i_bus_addr == 7'h3E);
  cov_stall: cover property (o_out_valid && !i_out_ready);
endmodule  // zdc_top_sva
bind zdc_top zdc_top_sva u_sva (.i_clk_sys, .i_arst_n, .i_bus_addr, .i_bus_wr, .i_bus_rd,
  .i_bus_wdata, .o_bus_rdata, .o_bus_ack, .o_converter_cal_mode, .o_cal_reset, .o_cal_dither,
  .o_cal_dac_corr, .o_out_valid, .i_out_ready, .o_out_i);
`default_nettype wire

// *** dv/test_zoom_decimation_control.sv ***
// Self-checking bench for the zoom/decimation control block
`timescale 1ns/10ps
`default_nettype none
module test_zoom_decimation_control;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [6:0]  addr;
  logic        wr, rd, ack, ok, sync, armed, trig, smp_v, smp_r, out_v, out_r;
  logic [15:0] wdata, rdata, q, smp_d, out_i, out_q;
  logic [1:0]  pack;
  logic [2:0]  mode;
  logic        c_rst, c_dith, c_gain, c_dac, c_err;
  logic        stalled = 1'b0;
  logic        tstate = 1'b0;
  logic [1:0]  meas = 2'b00;
  int          m_m, m_f, m_lp = 0, m_acc = 0, m_sel = 0;
  logic        m_filt = 1'b0;
  logic [15:0] exp_i [$];
  logic [15:0] st_op [4] = '{16'h0001, 16'h000e, 16'h000f, 16'h0001};
  logic [15:0] rc_op [4] = '{16'h0006, 16'h0006, 16'h0007, 16'h0007};
  int          fails = 0;
  int          check_count = 0;
  int          n_in = 0;
  int          n_out = 0;
  logic [31:0] seed = 32'hccd2_2640;
  logic [15:0] exp_stg [6];
  logic [15:0] saved [6];
  logic [15:0] mask [6] = '{16'h00ff, 16'h00e0, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00f8};
  always #10 clk = ~clk;
  zdc_bus_ctl u_bus (.i_clk_sys(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
    .i_rdata(rdata), .i_ack(ack));
  zdc_top DUT (.i_clk_sys(clk), .i_arst_n(arst_n), .i_bus_addr(addr), .i_bus_wr(wr),
    .i_bus_rd(rd), .i_bus_wdata(wdata), .o_bus_rdata(rdata), .o_bus_ack(ack), .i_sync(sync),
    .i_trig_state(tstate), .i_meas_code(meas), .i_armed(armed), .i_trig(trig),
    .i_pack_shift(pack), .o_converter_cal_mode(mode), .o_cal_reset(c_rst),
    .o_cal_dither(c_dith), .o_cal_gain_corr(c_gain), .o_cal_dac_corr(c_dac),
    .o_cal_err_update(c_err), .i_smp_valid(smp_v), .o_smp_ready(smp_r), .i_smp_data(smp_d),
    .o_out_valid(out_v), .i_out_ready(out_r), .o_out_i(out_i), .o_out_q(out_q));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [4:0] cal_exp(input int m);
    return {m == 0, m >= 2, m == 3 || m >= 5, m >= 4, m == 3 || m == 4 || m == 7};
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [6:0] a, input logic [15:0] d);
    u_bus.access(w, a, d, q, ok);
    check("ack", {15'h0, ok}, 16'h0001);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [15:0] e, input string nm);
    bus(1'b0, a, 16'h0000);
    check(nm, q, e);
  endtask
  task automatic put_stage();
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      bus(1'b1, 7'h30 + 7'(2 * i), seed[15:0]);
      exp_stg[i] = seed[15:0] & mask[i];
    end
  endtask
  task automatic chk_stage();
    for (int i = 0; i < 6; i++)
      rdchk(7'h30 + 7'(2 * i), exp_stg[i], "staging");
  endtask
  // Transfer by strobe, armed trigger, or timing-line fall (code 01 or trigger state)
  task automatic fire(input int how);
    if (how == 1) begin
      @(negedge clk);
      armed = 1'b1;
      trig = 1'b1;
      @(negedge clk);
      armed = 1'b0;
      trig = 1'b0;
    end else if (how >= 2) begin
      @(negedge clk);
      meas = (how == 2) ? 2'b01 : 2'b00;
      tstate = (how == 3);
      sync = 1'b0;
      repeat (6) @(negedge clk);
      sync = 1'b1;
      meas = 2'b00;
      tstate = 1'b0;
    end else
      bus(1'b1, 7'h3e, 16'hffff);
    repeat (3) @(negedge clk);
  endtask
  // Feed samples while the far side stalls, then drain and count words
  task automatic stream(input int sel, input int ns);
    int b_in;
    int b_out;
    b_in = n_in;
    b_out = n_out;
    bus(1'b1, 7'h28, u_bus.sel_word(sel));
    smp_v = 1'b1;
    for (int k = 0; k < 400 && n_in - b_in < ns; k++) begin
      @(negedge clk);
      seed = lfsr(seed);
      smp_d = seed[15:0];
      out_r = seed[3] & seed[7];
    end
    smp_v = 1'b0;
    out_r = 1'b1;
    repeat (40) @(negedge clk);
    check("words", 16'(n_out - b_out), 16'(ns >> sel));
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Reference model: counts, mixer at zero phase, lowpass and boxcar average
  always @(posedge clk) begin
    if (wr && addr == 7'h28)
      m_sel = int'(wdata[4:0]);
    if (wr && addr == 7'h2a)
      m_acc = 0;
    if (wr && addr == 7'h3c)
      m_filt = wdata[4];
    if (smp_v && smp_r) begin
      n_in <= n_in + 1;
      // Full-scale cosine of 127 at zero phase, scaled back by 7 bits
      m_m = (int'($signed(smp_d)) * 127) >>> 7;
      m_f = m_filt ? ((m_m + m_lp) >>> 1) : m_m;
      m_lp = m_m;
      m_acc = m_acc + m_f;
      if ((n_in & ((1 << m_sel) - 1)) == ((1 << m_sel) - 1)) begin
        exp_i.push_back(16'(m_acc >>> m_sel));
        m_acc = 0;
      end
    end
    if (smp_v && !smp_r)
      stalled <= 1'b1;
    if (out_v && out_r) begin
      n_out <= n_out + 1;
      check("q_at_zero_freq", out_q, 16'h0000);
      check("out_i", out_i, exp_i.pop_front());
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    {sync, armed, trig, smp_v, out_r, pack, smp_d} = {5'b10001, 2'b10, 16'h0000};
    repeat (3) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("cal_reset", {15'h0, c_rst}, 16'h0001);
    bus(1'b1, 7'h2c, 16'h1234);
    rdchk(7'h28, 16'h0200, "latch_lo");
    rdchk(7'h3c, 16'h0000, "write_only");
    rdchk(7'h40, 16'h0000, "unmapped");
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 7'h26, 16'(m << 5));  // ends in full calibration
      check("cal_mode", {13'h0, mode}, 16'(m));
      check("cal_decode", {11'h0, c_rst, c_dith, c_gain, c_dac, c_err}, 16'(cal_exp(m)));
    end
    $display("Test done: reset, capture, calibration");
    stream(0, 20);
    check("stalled", {15'h0, stalled}, 16'h0001);
    pack = 2'b01;
    bus(1'b1, 7'h2a, 16'hbeef);
    bus(1'b1, 7'h2c, 16'h0000);
    rdchk(7'h28, 16'h0114, "latch_lo");
    rdchk(7'h2a, 16'h0000, "latch_mid");
    rdchk(7'h2e, 16'h0000, "latch_top");
    bus(1'b1, 7'h3c, 16'h0010);
    stream(2, 8);
    $display("Test done: stream and decimation");
    for (int t = 0; t < 4; t++) begin
      put_stage();
      chk_stage();
      saved = exp_stg;
      bus(1'b1, 7'h3c, st_op[t]);
      fire(t);
      put_stage();
      bus(1'b1, 7'h3c, rc_op[t]);
      fire(0);
      exp_stg = saved;
      chk_stage();
    end
    rdchk(7'h28, 16'h011c, "trig_latch");
    bus(1'b1, 7'h3c, 16'h0080);
    @(negedge clk);
    sync = 1'b0;
    repeat (6) @(negedge clk);
    sync = 1'b1;
    bus(1'b1, 7'h3c, 16'h0006);
    fire(0);
    exp_stg = '{default: 16'h0000};
    chk_stage();
    $display("Test done: oscillator transfers");
    close_out();
  end
  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #(20 * 20000);
    fails++;
    close_out();
  end
endmodule  // test_zoom_decimation_control
`default_nettype wire
